// file: test/prc_ext_ctrl.sv
// model of the external controller wired to the discrete pins
// assumes requests come from the bench on mclk; pins are driven as levels
`timescale 1ns/1ps
module prc_ext_ctrl #(
    parameter int unsigned GAP_CYC = 30
) (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       pump_run,
    input  wire logic [5:0] want,
    input  wire logic       volt,
    output logic [6:0]      pins
);
    logic [15:0] gap_cnt;
    logic        run_q;
    logic [5:0]  act;

    // a restart is held back after every stop, shortened from seconds to cycles
    always_ff @(posedge mclk) begin
        run_q <= pump_run;
        if (sys_rst) begin
            gap_cnt <= 16'h0;
        end else if (run_q && !pump_run) begin
            gap_cnt <= GAP_CYC[15:0];
        end else if (gap_cnt != 16'h0) begin
            gap_cnt <= gap_cnt - 16'h1;
        end
    end

    // start only raised while the bench also asks for it, so permit ordering is the bench's
    assign act  = {want[5:2], want[1] && (gap_cnt == 16'h0), want[0]};
    // contact mode closes to common, so an asserted input reads low
    assign pins = {volt, volt ? act : ~act};
endmodule // prc_ext_ctrl

// file: test/prc_remote_io_test.sv
// self-checking bench for the pump discrete remote-control block
// assumes short hold parameters and the partner model on the pins
`timescale 1ns/1ps
module prc_remote_io_test;
    logic        mclk, sys_rst, drv_levitated, drv_power_fail, drv_accel, drv_brake;
    logic        drv_at_speed, drv_fault, drv_overload, ser_cmd_valid, reg_wr, reg_rd, volt;
    logic [1:0]  ser_cmd;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, seed;
    logic        pump_run, ser_cmd_discard, pwr_exp;
    logic [7:0]  status_relay_contacts;
    logic [2:0]  status_relay_nc;
    logic [6:0]  din_pins;
    logic [5:0]  want;
    int          error_cnt, total_checks, m, i;

    prc_remote_io #(.HOLD_CYC(20), .LONG_CYC(60), .PWRUP_CYC(200)) u_prc_remote_io (
        .mclk(mclk), .sys_rst(sys_rst), .din_pins(din_pins), .drv_levitated(drv_levitated),
        .drv_power_fail(drv_power_fail), .drv_accel(drv_accel), .drv_brake(drv_brake),
        .drv_at_speed(drv_at_speed), .drv_fault(drv_fault), .drv_overload(drv_overload),
        .ser_cmd_valid(ser_cmd_valid), .ser_cmd(ser_cmd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pump_run(pump_run),
        .ser_cmd_discard(ser_cmd_discard), .status_relay_contacts(status_relay_contacts),
        .status_relay_nc(status_relay_nc));
    prc_ext_ctrl #(.GAP_CYC(30)) u_prc_ext_ctrl (
        .mclk(mclk), .sys_rst(sys_rst), .pump_run(pump_run), .want(want), .volt(volt), .pins(din_pins));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // d: 0 accel, 1 brake, 2 at speed, 3 overload; no fault latched here
    function automatic logic [31:0] exp_relay(input logic [3:0] d, input logic pwr, input logic rem);
        return {21'h0, ~d[3], 1'b1, ~d[2], 1'b0, rem, d[3], 1'b0, d[2], d[1], d[0], pwr};
    endfunction

    task test_done;
        if (error_cnt == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // every wait ends just after an edge so outputs are settled
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task wait_run(input logic exp, input int max);
        for (int k = 0; k < max && pump_run !== exp; k++) cyc(1);
        chk_bit(pump_run, exp);
    endtask

    task pins_set(input logic [5:0] w, input logic v);
        @(posedge mclk);
        want <= w;
        volt <= v;
    endtask

    task reg_wr_t(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task reg_rd_t(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk_word(reg_rdata & mask, exp);
    endtask

    task send_cmd(input logic [1:0] c);
        @(posedge mclk);
        ser_cmd_valid <= 1'b1;
        ser_cmd       <= c;
        @(posedge mclk);
        ser_cmd_valid <= 1'b0;
        #1;
    endtask

    // whole run is near 1,200 cycles; a hang is cut at 10,000
    initial begin
        cyc(10000);
        error_cnt++;
        test_done();
    end

    initial begin
        {drv_levitated, drv_power_fail, drv_accel, drv_brake, drv_at_speed, drv_fault} = 6'h00;
        {drv_overload, ser_cmd_valid, reg_wr, reg_rd, volt, pwr_exp} = 6'h00;
        ser_cmd = 2'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        want = 6'h00;
        seed = 32'h28bd5b58;
        error_cnt = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        reg_rd_t(8'h08, 32'h00000700, 32'hffffffff);
        reg_rd_t(8'h0c, 32'h0, 32'hffffffff);
        reg_wr_t(8'h10, 32'hffffffff);
        reg_rd_t(8'h00, 32'h0, 32'hffffffff);
        pins_set(6'h23, 1'b0);
        cyc(40);
        chk_bit(pump_run, 1'b0);
        chk_bit(status_relay_contacts[6], 1'b1);
        reg_rd_t(8'h04, 32'h100, 32'h100);
        wait_run(1'b1, 80);
        pins_set(6'h22, 1'b0);
        wait_run(1'b0, 30);
        cyc(150);
        pins_set(6'h23, 1'b0);
        cyc(30);
        chk_bit(pump_run, 1'b0);
        wait_run(1'b1, 40);
        cyc(2);
        chk_bit(status_relay_contacts[7], 1'b1);
        pins_set(6'h2b, 1'b0);
        cyc(40);
        chk_bit(pump_run, 1'b1);
        pins_set(6'h3b, 1'b0);
        wait_run(1'b0, 30);
        pins_set(6'h39, 1'b0);
        cyc(40);
        pins_set(6'h3b, 1'b0);
        cyc(70);
        chk_bit(pump_run, 1'b0);
        pins_set(6'h21, 1'b0);
        cyc(30);
        pins_set(6'h23, 1'b0);
        cyc(10);
        pins_set(6'h21, 1'b0);
        cyc(30);
        pins_set(6'h23, 1'b0);
        cyc(32);
        chk_bit(pump_run, 1'b0);
        wait_run(1'b1, 30);
        pins_set(6'h20, 1'b0);
        wait_run(1'b0, 40);
        reg_wr_t(8'h00, 32'h1);
        pins_set(6'h20, 1'b1);
        cyc(40);
        pins_set(6'h22, 1'b1);
        wait_run(1'b1, 40);
        pins_set(6'h20, 1'b1);
        wait_run(1'b0, 40);
        pins_set(6'h22, 1'b1);
        wait_run(1'b1, 80);
        @(posedge mclk);
        drv_fault <= 1'b1;
        @(posedge mclk);
        drv_fault <= 1'b0;
        cyc(3);
        chk_bit(status_relay_contacts[4], 1'b1);
        chk_bit(status_relay_nc[1], 1'b0);
        pins_set(6'h24, 1'b1);
        cyc(30);
        chk_bit(status_relay_contacts[4], 1'b1);
        cyc(30);
        chk_bit(status_relay_contacts[4], 1'b0);
        chk_bit(status_relay_nc[1], 1'b1);
        pins_set(6'h20, 1'b1);
        cyc(30);
        send_cmd(2'h2);
        chk_bit(ser_cmd_discard, 1'b1);
        cyc(2);
        chk_bit(pump_run, 1'b0);
        reg_wr_t(8'h00, 32'h0);
        pins_set(6'h03, 1'b0);
        cyc(80);
        chk_bit(pump_run, 1'b0);
        chk_bit(status_relay_contacts[6], 1'b0);
        send_cmd(2'h2);
        chk_bit(pump_run, 1'b1);
        chk_bit(ser_cmd_discard, 1'b0);
        send_cmd(2'h1);
        chk_bit(pump_run, 1'b0);
        @(posedge mclk);
        drv_fault <= 1'b1;
        @(posedge mclk);
        drv_fault <= 1'b0;
        send_cmd(2'h3);
        chk_bit(status_relay_contacts[4], 1'b1);
        cyc(2);
        chk_bit(status_relay_contacts[4], 1'b0);
        pins_set(6'h00, 1'b0);
        cyc(30);
        for (m = 0; m < 2; m++) begin
            reg_wr_t(8'h00, {30'h0, m[0], 1'b0});
            for (i = 0; i < 20; i++) begin
                seed = lfsr(seed);
                @(posedge mclk);
                {drv_overload, drv_at_speed, drv_brake, drv_accel} <= seed[3:0];
                drv_levitated  <= seed[4];
                drv_power_fail <= seed[5] & ~seed[4];
                // power failure opens the contact, levitation closes it, otherwise it holds
                if (seed[5] & ~seed[4]) pwr_exp = 1'b0;
                else if (seed[4]) pwr_exp = 1'b1;
                cyc(4);
                chk_word({21'h0, status_relay_nc, status_relay_contacts},
                         exp_relay(seed[3:0], pwr_exp, m[0]));
            end
            reg_rd_t(8'h08, exp_relay(seed[3:0], pwr_exp, m[0]), 32'hffffffff);
        end
        test_done();
    end
endmodule // prc_remote_io_test

// file: verilog/prc_din_cond.sv
// three-flop synchroniser and debouncer for the discrete pins
// assumes pins are asynchronous to mclk; reset is synchronous
`timescale 1ns/1ps
`include "prc_params.svh"
module prc_din_cond (
    input  wire logic           mclk,
    input  wire logic           sys_rst,
    input  wire logic [6:0]     pins,
    prc_din_if.src              dout
);
    logic [2:0] sy  [`PRC_NIN];
    logic [7:0] cnt [`PRC_NIN];
    logic [6:0] busy;

    localparam logic [6:0] LEVEL_RST = `PRC_DIN_RST;

    for (genvar i = 0; i < `PRC_NIN; i++) begin : g_bit
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                sy[i] <= {3{LEVEL_RST[i]}};
            end else begin
                sy[i] <= {sy[i][1:0], pins[i]};
            end
        end

        // a change counts only once stages two and three agree for the whole window
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                cnt[i]         <= 8'h00;
                dout.level[i]  <= LEVEL_RST[i];
            end else if (sy[i][1] == sy[i][2] && sy[i][2] != dout.level[i]) begin
                if (cnt[i] == `PRC_DEB_CYC - 8'h01) begin
                    cnt[i]        <= 8'h00;
                    dout.level[i] <= sy[i][2];
                end else begin
                    cnt[i] <= cnt[i] + 8'h01;
                end
            end else begin
                cnt[i] <= 8'h00;
            end
        end
        assign busy[i] = (cnt[i] != 8'h00);
    end

    assign dout.settled = ~|busy;
endmodule // prc_din_cond

// file: verilog/prc_din_if.sv
// conditioned discrete input levels between conditioner and core
// assumes one clock domain, mclk
`timescale 1ns/1ps
interface prc_din_if;
    prc_pkg::prc_din_t level;
    logic              settled;
    modport src (output level, output settled);
    modport dst (input level, input settled);
endinterface

// file: verilog/prc_hold_timer.sv
// minimum-hold timer: done rises after en has stood limit cycles
// assumes en comes from conditioned logic on mclk
`timescale 1ns/1ps
`include "prc_params.svh"
module prc_hold_timer (
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    input  wire logic                  en,
    input  wire logic [`PRC_CNT_W-1:0] limit,
    output logic                       done
);
    logic [`PRC_CNT_W-1:0] cnt;

    always_ff @(posedge mclk) begin
        if (sys_rst || !en) begin
            cnt  <= '0;
            done <= 1'b0;
        end else if (cnt >= limit - `PRC_CNT_W'(1)) begin
            done <= 1'b1;
        end else begin
            cnt <= cnt + `PRC_CNT_W'(1);
        end
    end

    a_timer_restart: assert property (@(posedge mclk) disable iff (sys_rst) !en |=> !done)
        else $error("hold timer done without enable");
endmodule // prc_hold_timer

// file: verilog/prc_params.svh
// constants for the pump remote-control discrete io block
// assumes a 10 MHz controller clock; the millisecond hold counts derive from it, the debounce count does not
`ifndef PRC_PARAMS_SVH
`define PRC_PARAMS_SVH

`define PRC_CLK_HZ      10000000
`define PRC_HOLD_MS     300
`define PRC_LONG_MS     10000
`define PRC_PWRUP_MS    10000
`define PRC_MS_TO_CYC(ms) (((ms) * (`PRC_CLK_HZ / 1000)) < 1 ? 1 : ((ms) * (`PRC_CLK_HZ / 1000)))
`define PRC_CNT_W       27
`define PRC_DEB_CYC     8'h10

`define PRC_NIN         7
`define PRC_IN_PERMIT   0
`define PRC_IN_START    1
`define PRC_IN_FRESET   2
`define PRC_IN_INHIB    3
`define PRC_IN_QUAL     4
`define PRC_IN_REMOTE   5
`define PRC_IN_VSEL     6
`define PRC_DIN_RST     7'h3f

`define PRC_ADDR_CTRL   8'h00
`define PRC_ADDR_STATUS 8'h04
`define PRC_ADDR_RELAY  8'h08
`define PRC_CTRL_METHB  0
`define PRC_CTRL_SWREM  1
`define PRC_CTRL_RST    2'h0

`define PRC_REL_POWER   0
`define PRC_REL_ACCEL   1
`define PRC_REL_BRAKE   2
`define PRC_REL_SPEED   3
`define PRC_REL_FAULT   4
`define PRC_REL_WARN    5
`define PRC_REL_REMOTE  6
`define PRC_REL_RUN     7
`define PRC_NC_SPEED    0
`define PRC_NC_FAULT    1
`define PRC_NC_WARN     2

`endif

// file: verilog/prc_pkg.sv
// types for the pump remote-control discrete io block
// used by prc_din_if and prc_remote_io of the block
package prc_pkg;
    typedef enum logic [1:0] {
        PRC_CMD_NONE,
        PRC_CMD_STOP,
        PRC_CMD_RUN,
        PRC_CMD_RESET
    } prc_cmd_t;

    typedef enum {
        PRC_STOPPED,
        PRC_RUNNING
    } prc_run_t;

    typedef logic [6:0] prc_din_t;
endpackage

// file: verilog/prc_remote_io.sv
// discrete remote-control inputs and relay status outputs of the pump drive
// assumes drive status inputs and serial commands are on mclk; pins are not
`timescale 1ns/1ps
`include "prc_params.svh"
module prc_remote_io #(
    parameter int unsigned HOLD_CYC  = `PRC_MS_TO_CYC(`PRC_HOLD_MS),
    parameter int unsigned LONG_CYC  = `PRC_MS_TO_CYC(`PRC_LONG_MS),
    parameter int unsigned PWRUP_CYC = `PRC_MS_TO_CYC(`PRC_PWRUP_MS)
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [6:0]  din_pins,
    input  wire logic        drv_levitated,
    input  wire logic        drv_power_fail,
    input  wire logic        drv_accel,
    input  wire logic        drv_brake,
    input  wire logic        drv_at_speed,
    input  wire logic        drv_fault,
    input  wire logic        drv_overload,
    input  wire logic        ser_cmd_valid,
    input  wire logic [1:0]  ser_cmd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             pump_run,
    output logic             ser_cmd_discard,
    output logic [7:0]       status_relay_contacts,
    output logic [2:0]       status_relay_nc
);
    localparam logic [`PRC_CNT_W-1:0] HOLD_LIM  = `PRC_CNT_W'(HOLD_CYC);
    localparam logic [`PRC_CNT_W-1:0] LONG_LIM  = `PRC_CNT_W'(LONG_CYC);
    localparam logic [`PRC_CNT_W-1:0] PWRUP_LIM = `PRC_CNT_W'(PWRUP_CYC);

    prc_din_if din ();

    prc_pkg::prc_run_t     state;
    prc_pkg::prc_run_t     next_state;
    prc_pkg::prc_cmd_t     cmd;
    logic [1:0]            ctrl;
    logic [5:0]            act;
    logic                  vsel;
    logic                  remote_mode;
    logic                  permit;
    logic                  start;
    logic                  freset;
    logic                  inhib;
    logic                  method_b;
    logic                  just_up;
    logic [`PRC_CNT_W-1:0] up_cnt;
    logic [`PRC_CNT_W-1:0] start_lim;
    logic                  start_en;
    logic                  start_done;
    logic                  reset_done;
    logic                  ser_take;
    logic                  start_ok;
    logic                  stop_req;
    logic                  fault;
    logic                  power_ok;

    prc_din_cond u_cond (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pins    (din_pins),
        .dout    (din.src)
    );

    // contacts pull the pin low when closed; voltage drive makes it high
    assign vsel = din.level[`PRC_IN_VSEL];
    assign act  = din.level[5:0] ^ {6{~vsel}};

    assign method_b    = ctrl[`PRC_CTRL_METHB];
    assign remote_mode = act[`PRC_IN_REMOTE] | ctrl[`PRC_CTRL_SWREM];

    // every discrete control is masked outside remote mode
    assign permit = remote_mode & act[`PRC_IN_PERMIT];
    assign start  = remote_mode & act[`PRC_IN_START];
    assign freset = remote_mode & act[`PRC_IN_FRESET];
    assign inhib  = remote_mode & act[`PRC_IN_INHIB] & act[`PRC_IN_QUAL];

    // power-up window: the long hold applies until it has elapsed
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            up_cnt  <= '0;
            just_up <= 1'b1;
        end else if (just_up) begin
            if (up_cnt >= PWRUP_LIM - `PRC_CNT_W'(1)) begin
                just_up <= 1'b0;
            end else begin
                up_cnt <= up_cnt + `PRC_CNT_W'(1);
            end
        end
    end

    assign start_lim = just_up ? LONG_LIM : HOLD_LIM;
    assign start_en  = permit & start & ~method_b & ~inhib & (state == prc_pkg::PRC_STOPPED);

    prc_hold_timer u_start_tmr (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .en      (start_en),
        .limit   (start_lim),
        .done    (start_done)
    );

    prc_hold_timer u_reset_tmr (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .en      (freset),
        .limit   (HOLD_LIM),
        .done    (reset_done)
    );

    // serial commands only count in serial mode; the link itself is untouched
    assign cmd      = prc_pkg::prc_cmd_t'(ser_cmd);
    assign ser_take = ser_cmd_valid & ~remote_mode;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ser_cmd_discard <= 1'b0;
        end else begin
            ser_cmd_discard <= ser_cmd_valid & remote_mode;
        end
    end

    always_comb begin
        start_ok = 1'b0;
        stop_req = 1'b0;
        if (remote_mode) begin
            start_ok = method_b ? start : start_done;
            stop_req = method_b ? ~start : ~permit;
        end else if (ser_take) begin
            start_ok = (cmd == prc_pkg::PRC_CMD_RUN);
            stop_req = (cmd == prc_pkg::PRC_CMD_STOP);
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            prc_pkg::PRC_STOPPED: begin
                if (start_ok && !inhib && !fault) begin
                    next_state = prc_pkg::PRC_RUNNING;
                end
            end
            prc_pkg::PRC_RUNNING: begin
                if (stop_req || inhib || fault) begin
                    next_state = prc_pkg::PRC_STOPPED;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= prc_pkg::PRC_STOPPED;
        end else begin
            state <= next_state;
        end
    end

    assign pump_run = (state == prc_pkg::PRC_RUNNING);

    // a new fault in the clearing cycle wins, so none is lost
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fault <= 1'b0;
        end else if (drv_fault) begin
            fault <= 1'b1;
        end else if (reset_done || (ser_take && cmd == prc_pkg::PRC_CMD_RESET)) begin
            fault <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            power_ok <= 1'b0;
        end else if (drv_power_fail) begin
            power_ok <= 1'b0;
        end else if (drv_levitated) begin
            power_ok <= 1'b1;
        end
    end

    // relays follow state in any mode; coils are registered to avoid chatter
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_relay_contacts <= 8'h00;
            status_relay_nc       <= 3'h7;
        end else begin
            status_relay_contacts[`PRC_REL_POWER]  <= power_ok;
            status_relay_contacts[`PRC_REL_ACCEL]  <= drv_accel;
            status_relay_contacts[`PRC_REL_BRAKE]  <= drv_brake;
            status_relay_contacts[`PRC_REL_SPEED]  <= drv_at_speed;
            status_relay_contacts[`PRC_REL_FAULT]  <= fault;
            status_relay_contacts[`PRC_REL_WARN]   <= drv_overload;
            status_relay_contacts[`PRC_REL_REMOTE] <= remote_mode;
            status_relay_contacts[`PRC_REL_RUN]    <= pump_run;
            status_relay_nc[`PRC_NC_SPEED]         <= ~drv_at_speed;
            status_relay_nc[`PRC_NC_FAULT]         <= ~fault;
            status_relay_nc[`PRC_NC_WARN]          <= ~drv_overload;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl <= `PRC_CTRL_RST;
        end else if (reg_wr && reg_addr == `PRC_ADDR_CTRL) begin
            ctrl <= reg_wdata[1:0];
        end
    end

    // read data follows reg_rd one cycle late and stands as long as reg_rd is held; unmapped reads give zero
    always_ff @(posedge mclk) begin
        if (sys_rst || !reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            unique case (reg_addr)
                `PRC_ADDR_CTRL:   reg_rdata <= {30'h0, ctrl};
                `PRC_ADDR_STATUS: reg_rdata <= {20'h0, din.settled, just_up, fault,
                                                remote_mode, pump_run, din.level};
                `PRC_ADDR_RELAY:  reg_rdata <= {21'h0, status_relay_nc, status_relay_contacts};
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // independent hold counters for the checks below; they saturate instead of wrapping
    function automatic logic [`PRC_CNT_W-1:0] sat_inc(input logic [`PRC_CNT_W-1:0] v);
        return (v == '1) ? v : v + `PRC_CNT_W'(1);
    endfunction

    logic [`PRC_CNT_W-1:0] start_seen;
    logic [`PRC_CNT_W-1:0] reset_seen;

    always_ff @(posedge mclk) begin
        if (sys_rst || !start_en) begin
            start_seen <= '0;
        end else begin
            start_seen <= sat_inc(start_seen);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || !freset) begin
            reset_seen <= '0;
        end else begin
            reset_seen <= sat_inc(reset_seen);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_fault_seen;
        drv_fault ##1 fault;
    endsequence

    sequence s_method_a_start;
        remote_mode && !method_b && state == prc_pkg::PRC_STOPPED ##1 state == prc_pkg::PRC_RUNNING;
    endsequence

    a_serial_ignored: assert property (!remote_mode && !ser_cmd_valid && !pump_run |=> !pump_run)
        else $error("pump started without remote mode or serial command");
    a_start_needs_hold: assert property (s_method_a_start |-> $past(start_done))
        else $error("method A start without completed hold");
    a_powerup_limit: assert property (just_up |-> start_lim == LONG_LIM)
        else $error("short hold used during power-up window");
    a_permit_stop: assert property (pump_run && remote_mode && !method_b && !permit |=> !pump_run)
        else $error("pump kept running after permit dropped");
    a_level_stop: assert property (pump_run && remote_mode && method_b && !start |=> !pump_run)
        else $error("method B pump kept running with start low");
    a_fault_clear: assert property (reset_done && !drv_fault |=> !fault ##1 !status_relay_contacts[4])
        else $error("fault not cleared after reset hold");
    a_inhibit_stop: assert property (inhib |=> !pump_run)
        else $error("pump running while inhibited");
    a_qualify_gate: assert property (!act[`PRC_IN_QUAL] |-> !inhib)
        else $error("inhibit active without qualify");
    a_remote_force: assert property (act[`PRC_IN_REMOTE] |=> status_relay_contacts[6])
        else $error("remote enable did not select remote mode");
    a_serial_drop: assert property (ser_cmd_valid && remote_mode |=> ser_cmd_discard)
        else $error("serial command not dropped in remote mode");
    a_fault_relay: assert property (s_fault_seen |=> status_relay_contacts[4] && !status_relay_nc[1])
        else $error("fault contacts not switched");
    a_power_relay: assert property (drv_power_fail |=> ##1 !status_relay_contacts[0])
        else $error("power contact closed after power failure");
    a_speed_pair: assert property (status_relay_contacts[3] != status_relay_nc[0])
        else $error("at-speed contacts not complementary");
    a_start_count: assert property (start_done |-> start_seen >= HOLD_LIM)
        else $error("start hold finished too early");
    a_reset_count: assert property (reset_done |-> reset_seen >= HOLD_LIM)
        else $error("fault reset hold finished too early");
    a_level_start: assert property (remote_mode && method_b && start && !inhib && !fault && !pump_run |=> pump_run)
        else $error("method B start level did not start the pump");
    a_inhibit_refuse: assert property (inhib && !pump_run |=> !pump_run)
        else $error("pump started while inhibited");
    a_serial_run: assert property (ser_cmd_valid && !remote_mode && ser_cmd == 2'h2 && !fault |=> pump_run)
        else $error("serial run command not taken");
    a_serial_stop: assert property (ser_cmd_valid && !remote_mode && ser_cmd == 2'h1 |=> !pump_run)
        else $error("serial stop command not taken");
    a_serial_clear: assert property (ser_cmd_valid && !remote_mode && ser_cmd == 2'h3 && !drv_fault |=> !fault)
        else $error("serial reset command did not clear the fault");
    a_discard_only: assert property (!(ser_cmd_valid && remote_mode) |=> !ser_cmd_discard)
        else $error("discard pulse without a dropped command");
    a_reset_source: assert property ($fell(fault) |->
        $past(reset_done) || $past(ser_take) && $past(cmd) == prc_pkg::PRC_CMD_RESET)
        else $error("fault cleared without a reset");
    a_accel_relay: assert property (drv_accel |=> status_relay_contacts[1])
        else $error("accelerating contact open while accelerating");
    a_brake_relay: assert property (drv_brake |=> status_relay_contacts[2])
        else $error("braking contact open while braking");
    a_warn_pair: assert property (status_relay_contacts[5] != status_relay_nc[2])
        else $error("warning contacts not complementary");
    a_fault_pair: assert property (status_relay_contacts[4] != status_relay_nc[1])
        else $error("fault contacts not complementary");
    a_remote_relay: assert property (!remote_mode |=> !status_relay_contacts[6])
        else $error("remote contact closed outside remote mode");
    a_run_relay: assert property (pump_run |=> status_relay_contacts[7])
        else $error("running contact open while pump runs");
    a_levitate_relay: assert property (drv_levitated && !drv_power_fail |=> ##1 status_relay_contacts[0])
        else $error("power contact open after levitation");
endmodule // prc_remote_io
